// ---- cie_pkg.sv ----
// Package for the core instruction execute subset.
// Assumes a 14-bit instruction word and a 13-bit program counter.
package cie_pkg;
	localparam int unsigned INSN_W    = 14;
	localparam int unsigned PC_W      = 13;
	localparam int unsigned ADDR_W    = 7;
	localparam int unsigned DATA_W    = 8;
	localparam int unsigned JUMP_W    = 11;
	localparam int unsigned LATCH_LO  = 3;
	localparam int unsigned DEST_POS  = 7;
	localparam logic [2:0] OP_JUMP_TOP  = 3'h5;
	localparam logic [5:0] OP_OR_LIT_TOP = 6'h38;
	localparam logic [5:0] OP_OR_REG    = 6'h04;
	localparam logic [5:0] OP_INC_REG   = 6'h0a;
	localparam logic [5:0] OP_COPY_REG  = 6'h08;
	localparam logic [7:0] ACC_RESET    = 8'h00;
	localparam logic [12:0] PC_RESET    = 13'h0000;
	localparam logic [1:0] JUMP_CYCLES  = 2'h2;

	typedef enum logic [2:0] {CIE_NONE, CIE_JUMP, CIE_OR_LIT, CIE_OR_REG, CIE_INC_REG, CIE_COPY_REG} cie_op_e;

	// One write to the data-memory file.
	typedef struct packed {
		logic                    en;
		logic [ADDR_W-1:0]       addr;
		logic [DATA_W-1:0]       data;
	} cie_fwr_s;
endpackage : cie_pkg

// ---- cie_core.sv ----
// Execution of jump, OR literal, OR register, increment and copy instructions.
// Assumes the file read data for i_insn address is valid combinationally on i_file_rdata.
`timescale 1ns/1ns
module cie_core
	import cie_pkg::*;
(
	input  wire logic              i_clock,
	input  wire logic              i_srst,
	input  wire logic              i_ce,
	input  wire logic              i_insn_valid,
	input  wire logic [INSN_W-1:0] i_insn,
	input  wire logic [7:0]        i_upper_pc_latch,
	input  wire logic [DATA_W-1:0] i_file_rdata,
	output logic                   o_ready,
	output logic [PC_W-1:0]        o_pc,
	output logic [DATA_W-1:0]      o_acc,
	output logic                   o_zero,
	output cie_fwr_s               o_fwr
);

	// Decodes an instruction word into one of the handled operations.
	function automatic cie_op_e decode(input logic [INSN_W-1:0] w);
		cie_op_e r;
		r = CIE_NONE;
		if (w[13:11] == OP_JUMP_TOP)
			r = CIE_JUMP;
		else if (w[13:8] == OP_OR_LIT_TOP)
			r = CIE_OR_LIT;
		else if (w[13:8] == OP_OR_REG)
			r = CIE_OR_REG;
		else if (w[13:8] == OP_INC_REG)
			r = CIE_INC_REG;
		else if (w[13:8] == OP_COPY_REG)
			r = CIE_COPY_REG;
		return r;
	endfunction : decode

	logic [PC_W-1:0]   pc_q, pc_d;
	logic [DATA_W-1:0] acc_q, acc_d;
	logic              zero_q, zero_d;
	logic              ready_q, ready_d;
	cie_fwr_s          fwr_q, fwr_d;
	cie_op_e           op;
	logic [DATA_W-1:0] res;
	logic              dest_file;
	logic              upd;

	// Next-state computation for the execution unit.
	always_comb
	begin
		op        = decode(i_insn);
		pc_d      = pc_q;
		acc_d     = acc_q;
		zero_d    = zero_q;
		ready_d   = 1'b1;
		fwr_d     = '0;
		res       = i_file_rdata;
		upd       = 1'b0;
		dest_file = i_insn[DEST_POS];
		if (ready_q && i_insn_valid)
		begin
			pc_d = pc_q + 13'h0001;
			case (op)
				CIE_JUMP:
				begin
					pc_d   = {i_upper_pc_latch[4:LATCH_LO], i_insn[JUMP_W-1:0]};
					ready_d = 1'b0;
				end
				CIE_OR_LIT:
				begin
					res       = acc_q | i_insn[DATA_W-1:0];
					dest_file = 1'b0;
					upd       = 1'b1;
				end
				CIE_OR_REG:
				begin
					res = acc_q | i_file_rdata;
					upd = 1'b1;
				end
				CIE_INC_REG:
				begin
					res = i_file_rdata + 8'h01;
					upd = 1'b1;
				end
				CIE_COPY_REG:
				begin
					res = i_file_rdata;
					upd = 1'b1;
				end
				default:
				begin
					upd = 1'b0;
				end
			endcase
			if (upd)
			begin
				zero_d = (res == 8'h00);
				if (dest_file)
				begin
					fwr_d.en   = 1'b1;
					fwr_d.addr = i_insn[ADDR_W-1:0];
					fwr_d.data = res;
				end
				else
					acc_d = res;
			end
		end
	end

	// Registers, frozen while the clock enable is low except under synchronous reset.
	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			pc_q   <= PC_RESET;
			acc_q  <= ACC_RESET;
			zero_q <= 1'b0;
			ready_q <= 1'b1;
			fwr_q  <= '0;
		end
		else if (i_ce)
		begin
			pc_q   <= pc_d;
			acc_q  <= acc_d;
			zero_q <= zero_d;
			ready_q <= ready_d;
			fwr_q  <= fwr_d;
		end
	end

	// Every output comes straight from its register, so no logic sits between a flip-flop and a pin.
	assign o_pc    = pc_q;
	assign o_acc   = acc_q;
	assign o_zero  = zero_q;
	assign o_fwr   = fwr_q;
	assign o_ready = ready_q;

	// A jump holds the unit busy for exactly its second cycle.
	jump_two_cycle_a: assert property (@(posedge i_clock) disable iff (i_srst)
		(i_ce && o_ready && i_insn_valid && decode(i_insn) == CIE_JUMP) |=> (!o_ready && $stable(o_zero)))
		else $error("jump did not take a second cycle");

	// Jump target taken from operand and latch.
	jump_target_a: assert property (@(posedge i_clock) disable iff (i_srst)
		(i_ce && o_ready && i_insn_valid && decode(i_insn) == CIE_JUMP)
		|=> (o_pc == {$past(i_upper_pc_latch[4:3]), $past(i_insn[10:0])}))
		else $error("jump target wrong");

	// OR literal lands in the accumulator.
	or_literal_acc_a: assert property (@(posedge i_clock) disable iff (i_srst)
		(i_ce && o_ready && i_insn_valid && decode(i_insn) == CIE_OR_LIT)
		|=> (o_acc == ($past(o_acc) | $past(i_insn[7:0])) && !o_fwr.en))
		else $error("or literal result wrong");

	// Increment written to the file when the target bit is set.
	inc_file_write_a: assert property (@(posedge i_clock) disable iff (i_srst)
		(i_ce && o_ready && i_insn_valid && decode(i_insn) == CIE_INC_REG && i_insn[7])
		|=> (o_fwr.en && o_fwr.data == $past(i_file_rdata) + 8'h01 && $stable(o_acc)))
		else $error("increment write wrong");

	// OR register into the accumulator when the target bit is clear.
	or_reg_acc_a: assert property (@(posedge i_clock) disable iff (i_srst)
		(i_ce && o_ready && i_insn_valid && decode(i_insn) == CIE_OR_REG && !i_insn[7])
		|=> (o_acc == ($past(o_acc) | $past(i_file_rdata)) && !o_fwr.en))
		else $error("or register result wrong");

	// Copy to itself still reports zero.
	copy_zero_test_a: assert property (@(posedge i_clock) disable iff (i_srst)
		(i_ce && o_ready && i_insn_valid && decode(i_insn) == CIE_COPY_REG && i_insn[7])
		|=> (o_zero == ($past(i_file_rdata) == 8'h00) && o_fwr.en && o_ready))
		else $error("copy zero test wrong");

	// Zero flag matches the accumulator after an accumulator update.
	zero_from_acc_a: assert property (@(posedge i_clock) disable iff (i_srst)
		(i_ce && o_ready && i_insn_valid && decode(i_insn) inside {CIE_OR_LIT, CIE_INC_REG} && !i_insn[7])
		|=> (o_zero == (o_acc == 8'h00)))
		else $error("zero flag wrong");

	// Single-cycle operations never stall the unit.
	single_cycle_a: assert property (@(posedge i_clock) disable iff (i_srst)
		(i_ce && o_ready && i_insn_valid && decode(i_insn) inside {CIE_OR_LIT, CIE_OR_REG, CIE_INC_REG})
		|=> (o_ready && o_pc == $past(o_pc) + 13'h0001))
		else $error("single cycle op stalled");

	// Copy into the accumulator when the target bit is clear.
	copy_to_acc_a: assert property (@(posedge i_clock) disable iff (i_srst)
		(i_ce && o_ready && i_insn_valid && decode(i_insn) == CIE_COPY_REG && !i_insn[7])
		|=> (o_acc == $past(i_file_rdata) && !o_fwr.en && o_zero == ($past(i_file_rdata) == 8'h00)))
		else $error("copy to accumulator wrong");

	// OR register written back to the addressed file register.
	or_reg_file_a: assert property (@(posedge i_clock) disable iff (i_srst)
		(i_ce && o_ready && i_insn_valid && decode(i_insn) == CIE_OR_REG && i_insn[7])
		|=> (o_fwr.en && o_fwr.addr == $past(i_insn[6:0]) && o_fwr.data == ($past(o_acc) | $past(i_file_rdata))
			&& $stable(o_acc)))
		else $error("or register write wrong");

	// Increment into the accumulator when the target bit is clear.
	inc_to_acc_a: assert property (@(posedge i_clock) disable iff (i_srst)
		(i_ce && o_ready && i_insn_valid && decode(i_insn) == CIE_INC_REG && !i_insn[7])
		|=> (o_acc == $past(i_file_rdata) + 8'h01 && !o_fwr.en))
		else $error("increment to accumulator wrong");

	// Zero flag follows the written byte when the result goes to the file.
	zero_from_file_a: assert property (@(posedge i_clock) disable iff (i_srst)
		(i_ce && o_ready && i_insn_valid && decode(i_insn) inside {CIE_OR_REG, CIE_INC_REG, CIE_COPY_REG} && i_insn[7])
		|=> (o_zero == (o_fwr.data == 8'h00)))
		else $error("zero flag for file write wrong");

	// The second cycle of a jump ignores any offered word and then frees the unit.
	jump_second_cycle_a: assert property (@(posedge i_clock) disable iff (i_srst)
		(i_ce && !o_ready)
		|=> (o_ready && $stable(o_pc) && $stable(o_acc) && $stable(o_zero) && !o_fwr.en))
		else $error("jump second cycle not idle");
endmodule : cie_core

// ---- cie_core_bench.sv ----
// Self-checking bench for the instruction execute subset.
// Assumes cie_core with file read data driven by the bench for the addressed register.
`timescale 1ns/1ns
module cie_core_bench
	import cie_pkg::*;
;
	logic clock, srst, ce, insn_valid, ready, zero;
	logic [13:0] insn;
	logic [7:0]  latch, rdata, acc, acc_x;
	logic [12:0] pc, pc_x;
	cie_fwr_s    fwr;
	int          n_mismatch, tests_run;

	cie_core i_cie_core (.i_clock(clock), .i_srst(srst), .i_ce(ce), .i_insn_valid(insn_valid),
		.i_insn(insn), .i_upper_pc_latch(latch), .i_file_rdata(rdata), .o_ready(ready),
		.o_pc(pc), .o_acc(acc), .o_zero(zero), .o_fwr(fwr));

	// Free-running 100 MHz clock.
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish

	// Compares one observed value with its expectation.
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask : chk

	// Waits a bounded time for ready, presents one word, and lets the taking edge land.
	// Valid stays raised afterwards, so the next call replaces the word before any further edge.
	task automatic issue(input logic [13:0] w, input logic [7:0] d);
		int i;
		i = 0;
		while (ready !== 1'b1)
		begin
			if (i == 4)
			begin
				n_mismatch++;
				tally_and_finish;
			end
			i++;
			@(posedge clock);
			#1;
		end
		insn = w;
		rdata = d;
		insn_valid = 1'b1;
		@(posedge clock);
		#1;
	endtask : issue

	// Runs one byte or literal operation whose eight-bit result is r and checks every output except ready.
	task automatic run(input logic [5:0] op, input logic [7:0] f, input logic [7:0] d, input logic [7:0] r);
		logic to_file;
		to_file = (op != OP_OR_LIT_TOP) && f[7];
		issue({op, f}, d);
		pc_x = pc_x + 13'h1;
		if (!to_file)
			acc_x = r;
		chk("acc", acc_x, acc);
		chk("fwr_en", to_file, fwr.en);
		if (to_file)
			chk("fwr", {f[6:0], r}, {fwr.addr, fwr.data});
		chk("zero", r == 8'h00, zero);
		chk("pc", pc_x, pc);
	endtask : run

	// OR literal, zero result first, then back to back with a nonzero one.
	task automatic t_or_lit;
		run(OP_OR_LIT_TOP, 8'h00, 8'h00, acc_x);
		run(OP_OR_LIT_TOP, 8'h5a, 8'h00, acc_x | 8'h5a);
	endtask : t_or_lit

	// Increment with wrap to zero into the top file address, then into the accumulator.
	task automatic t_inc;
		run(OP_INC_REG, 8'hff, 8'hff, 8'h00);
		run(OP_INC_REG, 8'h05, 8'h41, 8'h42);
	endtask : t_inc

	// OR register to the file, then to the accumulator.
	task automatic t_or_reg;
		run(OP_OR_REG, 8'h80, 8'h81, acc_x | 8'h81);
		run(OP_OR_REG, 8'h00, 8'h10, acc_x | 8'h10);
	endtask : t_or_reg

	// Copy back to itself sets zero without touching the accumulator, then a jump keeps it.
	task automatic t_copy_jump;
		run(OP_COPY_REG, 8'ha3, 8'h00, 8'h00);
		latch = 8'h18;
		issue({3'h5, 11'h7ff}, 8'h00);
		pc_x = {latch[4:3], 11'h7ff};
		chk("pc", pc_x, pc);
		chk("ready", 1'b0, ready);
		chk("zero", 1'b1, zero);
		// A word offered in the jump's second cycle must be ignored.
		insn = {OP_OR_LIT_TOP, 8'hff};
		insn_valid = 1'b1;
		@(posedge clock);
		#1;
		chk("acc", acc_x, acc);
		chk("pc", pc_x, pc);
		chk("ready", 1'b1, ready);
		run(OP_COPY_REG, 8'h11, 8'h99, 8'h99);
	endtask : t_copy_jump

	// Mid-run reset after a file write with zero set, then a word on the first edge after release.
	task automatic t_reset;
		run(OP_INC_REG, 8'h80, 8'hff, 8'h00);
		srst = 1'b1;
		insn_valid = 1'b0;
		@(posedge clock);
		#1;
		chk("rst_pc", PC_RESET, pc);
		chk("rst_acc", ACC_RESET, acc);
		chk("rst_zero", 1'b0, zero);
		chk("rst_ready", 1'b1, ready);
		chk("rst_fwr_en", 1'b0, fwr.en);
		srst = 1'b0;
		pc_x = PC_RESET;
		acc_x = ACC_RESET;
		run(OP_OR_LIT_TOP, 8'h00, 8'h00, 8'h00);
	endtask : t_reset

	// An unhandled word only advances the program counter and leaves zero set.
	task automatic t_unknown;
		issue(14'h3fff, 8'h55);
		pc_x = pc_x + 13'h1;
		chk("acc", acc_x, acc);
		chk("fwr_en", 1'b0, fwr.en);
		chk("zero", 1'b1, zero);
		chk("pc", pc_x, pc);
	endtask : t_unknown

	// A low clock enable holds a presented word until the enable returns.
	task automatic t_freeze;
		ce = 1'b0;
		insn = {OP_OR_LIT_TOP, 8'h3c};
		rdata = 8'h00;
		repeat (2)
		begin
			@(posedge clock);
			#1;
		end
		chk("frz_pc", pc_x, pc);
		chk("frz_acc", acc_x, acc);
		chk("frz_zero", 1'b1, zero);
		ce = 1'b1;
		@(posedge clock);
		#1;
		pc_x = pc_x + 13'h1;
		acc_x = acc_x | 8'h3c;
		chk("acc", acc_x, acc);
		chk("zero", 1'b0, zero);
		chk("pc", pc_x, pc);
	endtask : t_freeze

	// Main sequence: reset, then every scenario.
	initial
	begin
		{ce, insn_valid, insn, latch, rdata} = '0;
		srst = 1'b1;
		n_mismatch = 0;
		tests_run = 0;
		pc_x = PC_RESET;
		acc_x = ACC_RESET;
		repeat (20) @(posedge clock);
		#1;
		srst = 1'b0;
		ce = 1'b1;
		t_or_lit;
		t_inc;
		t_or_reg;
		t_copy_jump;
		t_reset;
		t_unknown;
		t_freeze;
		tally_and_finish;
	end
endmodule : cie_core_bench
